// file: hw/qsw_ctrl.sv
// control, protection and diagnostic logic of a quad high-side switch
`timescale 1ns/10ps
`include "qsw_defs.svh"
module qsw_ctrl
	import qsw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic enable_in,
	input wire logic chip_sel_n,
	input wire logic [3:0] chan_in,
	input wire logic ser_clk,
	input wire qsw_analog_t analog_in,
	output logic [3:0] switch_on,
	output logic err_flag_o,
	output logic err_flag_oe,
	output logic overtemp_shutdown_flag_n,
	output logic diag_out,
	output logic diag_oe
);
	localparam int SW = 3 + `QSW_NCH + 4 * `QSW_NCH + 4;
	localparam int CNT_W = `QSW_CNT_W;
	localparam logic [CNT_W-1:0] ARM_CNT = CNT_W'(`QSW_ARM_CYCLES);
	localparam logic [CNT_W-1:0] ERR_CNT = CNT_W'(`QSW_ERR_CYCLES);
	localparam logic [3:0] LAST_BIT = 4'(`QSW_DIAG_BITS);

	// pins from outside are synchronised together
	logic [SW-1:0] raw_vec;
	logic [SW-1:0] syn_vec;
	assign raw_vec = {enable_in, chip_sel_n, ser_clk, chan_in, analog_in};
	qsw_sync #(.W(SW)) u_sync
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.async_in(raw_vec),
		.sync_out(syn_vec)
	);

	wire logic en_s = syn_vec[SW-1];
	wire logic cs_n_s = syn_vec[SW-2];
	wire logic sclk_s = syn_vec[SW-3];
	wire logic [3:0] chan_s = syn_vec[SW-4 -: 4];
	qsw_analog_t an_s;
	assign an_s = qsw_analog_t'(syn_vec[4*`QSW_NCH+3:0]);

	qsw_state_t state_reg;
	qsw_state_t state_next;
	logic [CNT_W-1:0] arm_cnt_reg;
	logic [CNT_W-1:0] arm_cnt_next;
	logic [CNT_W-1:0] err_cnt_reg;
	logic [CNT_W-1:0] err_cnt_next;
	logic err_low_reg;
	logic err_low_next;
	logic tsd_reg;
	logic ov_reg;
	logic [3:0] switch_reg;
	logic [3:0] switch_next;
	logic sclk_d_reg;
	logic [`QSW_DIAG_BITS-1:0] shift_reg;
	logic [`QSW_DIAG_BITS-1:0] shift_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic diag_reg;
	logic diag_next;
	logic diag_oe_reg;
	// registered pin drivers
	logic tsd_flag_reg;
	logic err_o_reg;

	// the temperature and voltage indicators already carry hysteresis
	wire logic active = (state_reg == QSW_ACTIVE);
	wire logic awake = (state_reg != QSW_SLEEP);
	wire logic force_off = tsd_reg | ov_reg | an_s.under_volt;
	wire logic [3:0] cmd_on = active ? chan_s : 4'h0;
	wire logic [3:0] ch_off_fault = ~cmd_on & (an_s.open_load | an_s.short_vcc);
	wire logic [3:0] ch_on_fault = cmd_on & (an_s.short_gnd | an_s.power_limit);
	wire logic glob_fault = an_s.temp_warn | an_s.over_volt | tsd_reg;
	wire logic any_fault = awake & (|ch_off_fault | |ch_on_fault | glob_fault);
	wire logic sclk_fall = sclk_d_reg & ~sclk_s;
	// channel 1 leaves first, so each nibble goes out lowest channel first
	wire logic [3:0] load_err_n = ~(ch_off_fault | ch_on_fault);
	wire logic [3:0] load_err_rev = {load_err_n[0], load_err_n[1],
		load_err_n[2], load_err_n[3]};
	wire logic [3:0] cmd_rev = {cmd_on[0], cmd_on[1], cmd_on[2], cmd_on[3]};
	wire logic [`QSW_DIAG_BITS-1:0] diag_word = {
		load_err_rev,
		cmd_rev,
		~an_s.temp_warn,
		~tsd_reg,
		~ov_reg
	};

	always_comb
	begin
		state_next = state_reg;
		arm_cnt_next = arm_cnt_reg;
		case (state_reg)
			QSW_SLEEP:
			begin
				arm_cnt_next = '0;
				if (en_s)
					state_next = QSW_ARMING;
			end
			QSW_ARMING:
			begin
				arm_cnt_next = arm_cnt_reg + 1'b1;
				if (arm_cnt_reg == ARM_CNT - 1'b1)
					state_next = QSW_ACTIVE;
			end
			QSW_ACTIVE:
				state_next = QSW_ACTIVE;
			default:
				state_next = QSW_SLEEP;
		endcase
		if (!en_s)
			state_next = QSW_SLEEP;
	end

	assign switch_next = force_off ? 4'h0 : cmd_on;

	always_comb
	begin
		err_cnt_next = '0;
		err_low_next = 1'b0;
		if (any_fault)
		begin
			err_cnt_next = err_cnt_reg;
			if (err_cnt_reg != ERR_CNT)
				err_cnt_next = err_cnt_reg + 1'b1;
			err_low_next = (err_cnt_reg == ERR_CNT);
		end
	end

	always_comb
	begin
		shift_next = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		diag_next = diag_reg;
		if (cs_n_s)
		begin
			shift_next = diag_word;
			bit_cnt_next = '0;
			diag_next = diag_word[`QSW_DIAG_BITS-1];
		end
		else if (sclk_fall)
		begin
			shift_next = {shift_reg[`QSW_DIAG_BITS-2:0], 1'b1};
			if (bit_cnt_reg != LAST_BIT)
				bit_cnt_next = bit_cnt_reg + 1'b1;
			diag_next = (bit_cnt_reg + 1'b1 >= LAST_BIT) ? 1'b1
				: shift_reg[`QSW_DIAG_BITS-2];
		end
	end

	// next values of the flags and pin drivers
	wire logic tsd_next = awake & an_s.temp_shutdown;
	wire logic ov_next = awake & an_s.over_volt;
	wire logic [3:0] switch_gated = awake ? switch_next : 4'h0;
	wire logic diag_oe_next = awake & ~cs_n_s;
	wire logic tsd_flag_next = awake & ~tsd_reg;
	// the flag pin only ever sinks current, so its data bit stays low
	wire logic err_o_next = 1'b0;

	// sequencing: sleep, arming, active
	// operating state
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			state_reg <= QSW_SLEEP;
		else
			state_reg <= state_next;
	end

	// arming delay counter
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			arm_cnt_reg <= '0;
		else
			arm_cnt_reg <= arm_cnt_next;
	end

	// error flag delay
	// error persistence counter
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			err_cnt_reg <= '0;
		else
			err_cnt_reg <= err_cnt_next;
	end

	// error flag pull-down request
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			err_low_reg <= 1'b0;
		else
			err_low_reg <= err_low_next;
	end

	// protection
	// thermal shutdown state
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			tsd_reg <= 1'b0;
		else
			tsd_reg <= tsd_next;
	end

	// overvoltage shutdown state
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			ov_reg <= 1'b0;
		else
			ov_reg <= ov_next;
	end

	// gate drive of the four switches
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			switch_reg <= 4'h0;
		else
			switch_reg <= switch_gated;
	end

	// thermal shutdown flag pin, low in sleep and in shutdown
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			tsd_flag_reg <= 1'b0;
		else
			tsd_flag_reg <= tsd_flag_next;
	end

	// error flag data bit
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			err_o_reg <= 1'b0;
		else
			err_o_reg <= err_o_next;
	end

	// serial diagnostic path
	// delayed serial clock for the falling edge detector
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			sclk_d_reg <= 1'b0;
		else
			sclk_d_reg <= sclk_s;
	end

	// diagnostic shift register
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			shift_reg <= '0;
		else
			shift_reg <= shift_next;
	end

	// count of bits shifted out
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			bit_cnt_reg <= '0;
		else
			bit_cnt_reg <= bit_cnt_next;
	end

	// serial data bit on the pin
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			diag_reg <= 1'b1;
		else
			diag_reg <= diag_next;
	end

	// serial data pin drive enable
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			diag_oe_reg <= 1'b0;
		else
			diag_oe_reg <= diag_oe_next;
	end

	// outputs come straight from their registers
	assign err_flag_o = err_o_reg;
	assign err_flag_oe = err_low_reg;
	assign overtemp_shutdown_flag_n = tsd_flag_reg;
	assign switch_on = switch_reg;
	assign diag_out = diag_reg;
	assign diag_oe = diag_oe_reg;
endmodule : qsw_ctrl

// file: hw/qsw_defs.svh
// constants of the quad switch control logic
// Overview of operation
// - enable low: sleep, switches off, flags fixed
// - ignore channel inputs 30 us after enable
// - enabled, fault free: switch follows its input
// - off channel: open, short-to-supply, hot, overvoltage flag
// - on channel: short, power limit, hot, overvoltage flag
// - above 170 C: all off, both flags low
// - chip select high: data output high impedance
// - chip select low while enabled: data output driven
// - overvoltage forces all off until hysteresis clears
// - undervoltage forces all switches off
// - thermal shutdown releases when die cools
// - error flag delayed 75 us, masks short faults
// - 11-bit diagnostic word, fault bits active low
// - data changes on falling serial clock edge
`ifndef QSW_DEFS_SVH
`define QSW_DEFS_SVH
`define QSW_CLK_PERIOD_PS 5000
`define QSW_ARM_TIME_US 30
`define QSW_ARM_CYCLES ((`QSW_ARM_TIME_US * 1000000) / `QSW_CLK_PERIOD_PS)
`define QSW_ERR_TIME_US 75
`define QSW_ERR_CYCLES ((`QSW_ERR_TIME_US * 1000000) / `QSW_CLK_PERIOD_PS)
`define QSW_CNT_W 16
`define QSW_NCH 4
`define QSW_DIAG_BITS 11
`define QSW_BIT_CNT_W 4
`define QSW_SYNC_W 3
`endif

// file: hw/qsw_pkg.sv
// types of the quad switch control logic
package qsw_pkg;
	typedef struct packed {
		logic [3:0] open_load;
		logic [3:0] short_vcc;
		logic [3:0] short_gnd;
		logic [3:0] power_limit;
		logic temp_warn;
		logic temp_shutdown;
		logic over_volt;
		logic under_volt;
	} qsw_analog_t;
	typedef enum logic [1:0] {
		QSW_SLEEP,
		QSW_ARMING,
		QSW_ACTIVE
	} qsw_state_t;
endpackage : qsw_pkg

// file: hw/qsw_sync.sv
// three-stage synchroniser with second/third agreement
`timescale 1ns/10ps
module qsw_sync
#(
	parameter int W = 1
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] out_reg;
	wire logic [W-1:0] agree = ~(s2_reg ^ s3_reg);
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end
		else
		begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= (agree & s3_reg) | (~agree & out_reg);
		end
	end
	assign sync_out = out_reg;
endmodule : qsw_sync

// file: verif/qsw_host_model.sv
// host side view of the shared error and diagnostic lines
`timescale 1ns/10ps
module qsw_host_model
(
	input wire logic ref_clk,
	input wire logic err_flag_oe,
	input wire logic diag_out,
	input wire logic diag_oe,
	output logic err_wire,
	output logic diag_wire
);
	logic float_reg = 1'b0;
	always_ff @(posedge ref_clk)
	begin
		float_reg <= ~float_reg;
	end
	// pull-up holds the flag high unless a device sinks it
	assign err_wire = ~err_flag_oe;
	// released line toggles so a stale bit is never read
	assign diag_wire = diag_oe ? diag_out : float_reg;
endmodule : qsw_host_model

// file: verif/qsw_ctrl_asserts.sv
// port assertions of the quad switch control logic
`timescale 1ns/10ps
module qsw_ctrl_asserts
	import qsw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic enable_in,
	input wire logic chip_sel_n,
	input wire qsw_analog_t analog_in,
	input wire logic [3:0] switch_on,
	input wire logic err_flag_o,
	input wire logic err_flag_oe,
	input wire logic overtemp_shutdown_flag_n,
	input wire logic diag_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [15:0] en_cnt_reg;
	logic [15:0] flt_cnt_reg;
	wire counting = rst_n && enable_in;
	always_ff @(posedge ref_clk)
	begin
		en_cnt_reg <= counting ? en_cnt_reg + 16'h1 : 16'h0;
		flt_cnt_reg <= (counting && |analog_in) ? flt_cnt_reg + 16'h1 : 16'h0;
	end
	sequence s_cs_hi;
		chip_sel_n [*8];
	endsequence
	sequence s_cs_lo;
		(enable_in && !chip_sel_n) [*8];
	endsequence
	property p_sleep;
		(!enable_in) [*8] |=> switch_on == 4'h0 && !err_flag_oe
			&& !overtemp_shutdown_flag_n;
	endproperty
	property p_arm;
		|switch_on && enable_in |-> en_cnt_reg > 16'h1766;
	endproperty
	property p_tsd;
		(enable_in && analog_in.temp_shutdown) [*8] |=>
			!overtemp_shutdown_flag_n && switch_on == 4'h0;
	endproperty
	property p_ov;
		analog_in.over_volt [*8] |=> switch_on == 4'h0;
	endproperty
	property p_uv;
		analog_in.under_volt [*8] |=> switch_on == 4'h0;
	endproperty
	property p_hiz;
		s_cs_hi |=> !diag_oe;
	endproperty
	property p_drv;
		s_cs_lo |=> diag_oe;
	endproperty
	property p_delay;
		$rose(err_flag_oe) |-> flt_cnt_reg > 16'h3a8e;
	endproperty
	property p_od;
		err_flag_o == 1'b0;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep");
	a_arm: assert property (p_arm) else $error("arming");
	a_tsd: assert property (p_tsd) else $error("shutdown");
	a_ov: assert property (p_ov) else $error("overvoltage");
	a_uv: assert property (p_uv) else $error("undervoltage");
	a_hiz: assert property (p_hiz) else $error("hi z");
	a_drv: assert property (p_drv) else $error("drive");
	a_delay: assert property (p_delay) else $error("flag delay");
	a_od: assert property (p_od) else $error("open drain");
endmodule : qsw_ctrl_asserts
bind qsw_ctrl qsw_ctrl_asserts i_chk (.ref_clk, .rst_n, .enable_in,
	.chip_sel_n, .analog_in, .switch_on, .err_flag_o, .err_flag_oe,
	.overtemp_shutdown_flag_n, .diag_oe);

// file: verif/qsw_ctrl_test.sv
// self-checking bench of the quad switch control logic
`timescale 1ns/10ps
module qsw_ctrl_test
	import qsw_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic enable_in = 1'b0;
	logic chip_sel_n = 1'b1;
	logic ser_clk = 1'b0;
	logic [3:0] chan_in = 4'h0;
	qsw_analog_t analog_in = '0;
	logic [3:0] switch_on;
	logic err_flag_o, err_flag_oe, overtemp_shutdown_flag_n;
	logic diag_out, diag_oe, err_wire, diag_wire;
	logic [10:0] word;
	int mismatches = 0;
	int samples_checked = 0;
	always #2.5 ref_clk = ~ref_clk;
	qsw_ctrl i_dut (.ref_clk, .rst_n, .enable_in, .chip_sel_n, .chan_in,
		.ser_clk, .analog_in, .switch_on, .err_flag_o, .err_flag_oe,
		.overtemp_shutdown_flag_n, .diag_out, .diag_oe);
	qsw_host_model i_host (.ref_clk, .err_flag_oe, .diag_out, .diag_oe,
		.err_wire, .diag_wire);
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic read_diag(output logic [10:0] w);
		chip_sel_n = 1'b0;
		tick(110);
		chk(diag_oe, 1'b1);
		for (int i = 10; i >= 0; i--)
		begin
			ser_clk = 1'b1;
			w[i] = diag_wire;
			tick(10);
			ser_clk = 1'b0;
			tick(10);
		end
		chk(diag_wire, 1'b1);
		chip_sel_n = 1'b1;
		tick(10);
		chk(diag_oe, 1'b0);
	endtask : read_diag
	initial
	begin
		tick(8);
		rst_n = 1'b1;
		chan_in = 4'h5;
		tick(20);
		chk({switch_on, err_wire, overtemp_shutdown_flag_n}, 6'h02);
		enable_in = 1'b1;
		tick(3000);
		chk(switch_on, 4'h0);
		tick(3100);
		chk({switch_on, err_wire, overtemp_shutdown_flag_n}, 6'h17);
		$display("test arming done");
		// shutdown, overvoltage, undervoltage in turn, each too short to set the error flag
		for (int k = 0; k < 3; k++)
		begin
			analog_in[2-k] = 1'b1;
			tick(20);
			chk({switch_on, err_wire, overtemp_shutdown_flag_n},
				{4'h0, 1'b1, k != 0});
			analog_in = '0;
			tick(20);
			chk(switch_on, 4'h5);
		end
		$display("test forced off done");
		analog_in.open_load = 4'h2;
		analog_in.short_gnd = 4'h1;
		tick(14900);
		chk(err_wire, 1'b1);
		tick(200);
		chk(err_wire, 1'b0);
		read_diag(word);
		chk(word, 11'h1d7);
		$display("test faults done");
		analog_in = '0;
		enable_in = 1'b0;
		tick(20);
		chk({switch_on, err_wire, overtemp_shutdown_flag_n}, 6'h02);
		$display("test sleep done");
		stop_test();
	end
endmodule : qsw_ctrl_test
